/* pkg/gdl_regs.svh */
`ifndef GDL_REGS_SVH
`define GDL_REGS_SVH

`define GDL_ADDR_W          4
`define GDL_DATA_W          16
`define GDL_REG_W           11

`define GDL_ADDR_FAULT      4'h0
`define GDL_ADDR_DRV_CTRL   4'h2
`define GDL_ADDR_HS_DRIVE   4'h3
`define GDL_ADDR_LOCK_STAT  4'h7

`define GDL_LOCK_CODE       3'h6
`define GDL_UNLOCK_CODE     3'h3

`define GDL_LOCK_MSB        10
`define GDL_LOCK_LSB        8
`define GDL_SRC_MSB         7
`define GDL_SRC_LSB         4
`define GDL_SINK_MSB        3
`define GDL_SINK_LSB        0
`define GDL_LOCKED_WRITE_MSB 2
`define GDL_CLR_BIT         0
`define GDL_BRAKE_BIT       1
`define GDL_COAST_BIT       2

`define GDL_HS_RESET        11'h3ff
`define GDL_DRV_RESET       11'h000

`define GDL_STAT_LOCKED_BIT  0
`define GDL_STAT_IGNORED_BIT 1

`define GDL_MA_W            12

`endif

/* pkg/gdl_pkg.sv */
`include "gdl_regs.svh"

package gdl_pkg;

   typedef enum logic
   {
      gdl_unlocked,
      gdl_locked
   } gdl_lock_state_t;

   typedef struct packed
   {
      logic [2:0] lock;
      logic [3:0] hs_source_current_code;
      logic [3:0] hs_sink_current_field;
   } gdl_hs_t;

   typedef struct packed
   {
      logic       ocp_all_bridges;
      logic       dis_gate_uv;
      logic       dis_gate_fault;
      logic       otw_report;
      logic [1:0] pwm_mode;
      logic       one_pwm_async;
      logic       one_pwm_dir;
      logic       coast;
      logic       brake;
      logic       fault_clear_bit;
   } gdl_drv_t;

   typedef struct packed
   {
      logic                    wr;
      logic                    rd;
      logic [`GDL_ADDR_W-1:0]  addr;
      logic [`GDL_DATA_W-1:0]  wdata;
   } gdl_bus_req_t;

endpackage : gdl_pkg

/* rtl/gdl_idrive_decode.sv */
`timescale 1ns/1ns
`default_nettype none
`include "gdl_regs.svh"

module gdl_idrive_decode
   import gdl_pkg::*;
(
   input  wire logic                  clock,
   input  wire logic                  rst,
   input  wire logic [3:0]            hs_source_current_code,
   input  wire logic [3:0]            hs_sink_current_code,
   output var  logic [`GDL_MA_W-1:0]  source_ma,
   output var  logic [`GDL_MA_W-1:0]  sink_ma
);

   function automatic logic [`GDL_MA_W-1:0] gdl_source_ma(input logic [3:0] code);
      unique case (code)
         4'h0, 4'h1: gdl_source_ma = 12'd50;
         4'h2:       gdl_source_ma = 12'd100;
         4'h3:       gdl_source_ma = 12'd150;
         4'h4:       gdl_source_ma = 12'd300;
         4'h5:       gdl_source_ma = 12'd350;
         4'h6:       gdl_source_ma = 12'd400;
         4'h7:       gdl_source_ma = 12'd450;
         4'h8:       gdl_source_ma = 12'd550;
         4'h9:       gdl_source_ma = 12'd600;
         4'ha:       gdl_source_ma = 12'd650;
         4'hb:       gdl_source_ma = 12'd700;
         4'hc:       gdl_source_ma = 12'd850;
         4'hd:       gdl_source_ma = 12'd900;
         4'he:       gdl_source_ma = 12'd950;
         4'hf:       gdl_source_ma = 12'd1000;
      endcase
   endfunction : gdl_source_ma

   // Sink steps are twice the source steps from 0010b upward
   function automatic logic [`GDL_MA_W-1:0] gdl_sink_ma(input logic [3:0] code);
      unique case (code)
         4'h0, 4'h1: gdl_sink_ma = 12'd100;
         4'h2:       gdl_sink_ma = 12'd200;
         4'h3:       gdl_sink_ma = 12'd300;
         4'h4:       gdl_sink_ma = 12'd600;
         4'h5:       gdl_sink_ma = 12'd700;
         4'h6:       gdl_sink_ma = 12'd800;
         4'h7:       gdl_sink_ma = 12'd900;
         4'h8:       gdl_sink_ma = 12'd1100;
         4'h9:       gdl_sink_ma = 12'd1200;
         4'ha:       gdl_sink_ma = 12'd1300;
         4'hb:       gdl_sink_ma = 12'd1400;
         4'hc:       gdl_sink_ma = 12'd1700;
         4'hd:       gdl_sink_ma = 12'd1800;
         4'he:       gdl_sink_ma = 12'd1900;
         4'hf:       gdl_sink_ma = 12'd2000;
      endcase
   endfunction : gdl_sink_ma

   logic [`GDL_MA_W-1:0] next_source_ma;
   logic [`GDL_MA_W-1:0] next_sink_ma;

   always_comb
   begin
      next_source_ma = gdl_source_ma(hs_source_current_code);
      next_sink_ma   = gdl_sink_ma(hs_sink_current_code);
   end

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         source_ma <= 12'd1000;
         sink_ma   <= 12'd2000;
      end
      else
      begin
         source_ma <= next_source_ma;
         sink_ma   <= next_sink_ma;
      end
   end

endmodule : gdl_idrive_decode

`default_nettype wire

/* rtl/gdl_top.sv */
// Our own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "gdl_regs.svh"

module gdl_top
   import gdl_pkg::*;
#(
   parameter int FAULT_W = 11
)
(
   input  wire logic                    clock,
   input  wire logic                    rst,
   input  wire logic [`GDL_ADDR_W-1:0]  addr,
   input  wire logic [`GDL_DATA_W-1:0]  wr_data,
   input  wire logic                    wr_strobe,
   input  wire logic                    rd_strobe,
   output var  logic [`GDL_DATA_W-1:0]  rd_data,
   input  wire logic [FAULT_W-1:0]      fault_event,
   output var  logic [FAULT_W-1:0]      latched_faults,
   output var  logic                    fault_clear_pulse,
   output var  gdl_hs_t                 hs_cfg,
   output var  gdl_drv_t                drv_cfg,
   output var  logic                    locked,
   output var  logic [`GDL_MA_W-1:0]    source_ma,
   output var  logic [`GDL_MA_W-1:0]    sink_ma
);

   initial
   begin
      if (FAULT_W < 1 || FAULT_W > `GDL_DATA_W)
      begin
         $error("FAULT_W must lie between 1 and the data width");
      end
      // Refuse register types that the padded read path cannot carry
      if ($bits(gdl_hs_t) != `GDL_REG_W || $bits(gdl_drv_t) != `GDL_REG_W)
      begin
         $error("Register structs must match the register width");
      end
   end

   gdl_bus_req_t req;

   always_comb
   begin
      req.wr    = wr_strobe;
      req.rd    = rd_strobe;
      req.addr  = addr;
      req.wdata = wr_data;
   end

   // Fault inputs arrive from analog comparators, so they are synchronised first
   logic [FAULT_W-1:0] fault_meta;
   logic [FAULT_W-1:0] fault_sync;
   logic [FAULT_W-1:0] next_fault_meta;
   logic [FAULT_W-1:0] next_fault_sync;

   always_comb
   begin
      next_fault_meta = fault_event;
      next_fault_sync = fault_meta;
   end

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         fault_meta <= '0;
         fault_sync <= '0;
      end
      else
      begin
         fault_meta <= next_fault_meta;
         fault_sync <= next_fault_sync;
      end
   end

   function automatic logic gdl_hit(input gdl_bus_req_t r, input logic [`GDL_ADDR_W-1:0] a);
      gdl_hit = r.wr && (r.addr == a);
   endfunction : gdl_hit

   function automatic logic [`GDL_DATA_W-1:0] gdl_pad(input logic [`GDL_REG_W-1:0] v);
      gdl_pad = {{(`GDL_DATA_W-`GDL_REG_W){1'b0}}, v};
   endfunction : gdl_pad

   // Lock state, configuration fields and ignored-write flag
   gdl_lock_state_t    lock_state;
   gdl_lock_state_t    next_lock_state;
   gdl_hs_t            next_hs_cfg;
   gdl_drv_t           next_drv_cfg;
   logic               write_ignored;
   logic               next_write_ignored;
   logic [FAULT_W-1:0] next_latched_faults;
   logic [2:0]         lock_wr;
   logic               wr_drv;
   logic               wr_hs;
   logic               wr_stat;
   logic               clear_req;
   logic               ignore_now;

   always_comb
   begin
      wr_drv     = gdl_hit(req, `GDL_ADDR_DRV_CTRL);
      wr_hs      = gdl_hit(req, `GDL_ADDR_HS_DRIVE);
      wr_stat    = gdl_hit(req, `GDL_ADDR_LOCK_STAT);
      lock_wr    = req.wdata[`GDL_LOCK_MSB:`GDL_LOCK_LSB];
      clear_req  = wr_drv && req.wdata[`GDL_CLR_BIT];
      ignore_now = 1'b0;

      next_lock_state = lock_state;
      next_hs_cfg     = hs_cfg;
      next_drv_cfg    = drv_cfg;
      // Self-clearing: high for exactly one cycle after the write
      next_drv_cfg.fault_clear_bit = clear_req;

      if (wr_drv)
      begin
         unique case (lock_state)
            gdl_unlocked:
            begin
               next_drv_cfg = gdl_drv_t'(req.wdata[`GDL_REG_W-1:0]);
               next_drv_cfg.fault_clear_bit = clear_req;
            end
            gdl_locked:
            begin
               // Fault clear, brake and coast stay writable for emergency stops
               next_drv_cfg.coast           = req.wdata[`GDL_COAST_BIT];
               next_drv_cfg.brake           = req.wdata[`GDL_BRAKE_BIT];
               next_drv_cfg.fault_clear_bit = clear_req;
               // Only frozen bits count, so rewriting the stored value is not flagged
               ignore_now = (req.wdata[`GDL_REG_W-1:`GDL_LOCKED_WRITE_MSB+1]
                             != drv_cfg[`GDL_REG_W-1:`GDL_LOCKED_WRITE_MSB+1]);
            end
         endcase
      end

      if (wr_hs)
      begin
         unique case (lock_state)
            gdl_unlocked:
            begin
               // Fields of the locking write itself still land
               next_hs_cfg.hs_source_current_code =
                  req.wdata[`GDL_SRC_MSB:`GDL_SRC_LSB];
               next_hs_cfg.hs_sink_current_field =
                  req.wdata[`GDL_SINK_MSB:`GDL_SINK_LSB];
               if (lock_wr == `GDL_LOCK_CODE)
               begin
                  next_lock_state = gdl_locked;
               end
               else
               begin
                  next_lock_state = gdl_unlocked;
               end
            end
            gdl_locked:
            begin
               if (lock_wr == `GDL_UNLOCK_CODE)
               begin
                  next_lock_state = gdl_unlocked;
               end
               else
               begin
                  next_lock_state = gdl_locked;
               end
               ignore_now = (req.wdata[`GDL_SRC_MSB:`GDL_SINK_LSB]
                             != {hs_cfg.hs_source_current_code,
                                 hs_cfg.hs_sink_current_field});
            end
         endcase
      end

      next_hs_cfg.lock = (next_lock_state == gdl_locked) ?
                         `GDL_LOCK_CODE : `GDL_UNLOCK_CODE;
   end

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         lock_state     <= gdl_unlocked;
         hs_cfg         <= gdl_hs_t'(`GDL_HS_RESET);
         drv_cfg        <= gdl_drv_t'(`GDL_DRV_RESET);
      end
      else
      begin
         lock_state     <= next_lock_state;
         hs_cfg         <= next_hs_cfg;
         drv_cfg        <= next_drv_cfg;
      end
   end

   // A new discarded write wins over a clear in the same cycle
   always_comb
   begin
      next_write_ignored = write_ignored;
      if (wr_stat && req.wdata[`GDL_STAT_IGNORED_BIT])
      begin
         next_write_ignored = 1'b0;
      end
      if (ignore_now)
      begin
         next_write_ignored = 1'b1;
      end
   end

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         write_ignored <= 1'b0;
      end
      else
      begin
         write_ignored <= next_write_ignored;
      end
   end

   // Faults present during the clear re-latch at once
   always_comb
   begin
      next_latched_faults = latched_faults | fault_sync;
      if (clear_req)
      begin
         next_latched_faults = fault_sync;
      end
   end

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         latched_faults <= '0;
      end
      else
      begin
         latched_faults <= next_latched_faults;
      end
   end

   always_comb
   begin
      locked            = (lock_state == gdl_locked);
      fault_clear_pulse = drv_cfg.fault_clear_bit;
   end

   // Read path: data stands in the cycle after the strobe only
   logic [`GDL_DATA_W-1:0] next_rd_data;
   logic [`GDL_DATA_W-1:0] drv_view;

   always_comb
   begin
      drv_view    = gdl_pad(drv_cfg);
      drv_view[`GDL_CLR_BIT] = 1'b0;
      // Unmapped addresses read zero
      next_rd_data = '0;
      if (req.rd)
      begin
         if (req.addr == `GDL_ADDR_FAULT)
         begin
            next_rd_data[FAULT_W-1:0] = latched_faults;
         end
         else if (req.addr == `GDL_ADDR_DRV_CTRL)
         begin
            next_rd_data = drv_view;
         end
         else if (req.addr == `GDL_ADDR_HS_DRIVE)
         begin
            next_rd_data = gdl_pad(hs_cfg);
         end
         else if (req.addr == `GDL_ADDR_LOCK_STAT)
         begin
            next_rd_data[`GDL_STAT_LOCKED_BIT]  = locked;
            next_rd_data[`GDL_STAT_IGNORED_BIT] = write_ignored;
         end
      end
   end

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         rd_data <= '0;
      end
      else
      begin
         rd_data <= next_rd_data;
      end
   end

   // Decoded currents lag the stored codes by one cycle
   gdl_idrive_decode u_decode
   (
      .clock                  (clock),
      .rst                    (rst),
      .hs_source_current_code (hs_cfg.hs_source_current_code),
      .hs_sink_current_code   (hs_cfg.hs_sink_current_field),
      .source_ma              (source_ma),
      .sink_ma                (sink_ma)
   );

endmodule : gdl_top

`default_nettype wire

/* tb/gdl_host.sv */
`timescale 1ns/1ns
`default_nettype none
`include "gdl_regs.svh"

module gdl_host
   import gdl_pkg::*;
(
   input  wire logic                   clock,
   output var  logic [`GDL_ADDR_W-1:0] addr,
   output var  logic [`GDL_DATA_W-1:0] wr_data,
   output var  logic                   wr_strobe,
   output var  logic                   rd_strobe,
   input  wire logic [`GDL_DATA_W-1:0] rd_data
);
   initial
   begin
      addr = '0;
      wr_data = '0;
      wr_strobe = 1'b0;
      rd_strobe = 1'b0;
   end

   // Released data lines show the inverse so stale values cannot look valid
   task wr(input logic [3:0] a, input logic [15:0] d);
      begin
         @(posedge clock);
         addr <= a;
         wr_data <= d;
         wr_strobe <= 1'b1;
         @(posedge clock);
         wr_strobe <= 1'b0;
         wr_data <= ~d;
      end
   endtask : wr

   // Data stand only in the cycle after the strobe, so sample mid-cycle
   task rd(input logic [3:0] a, output logic [15:0] d);
      begin
         @(posedge clock);
         addr <= a;
         rd_strobe <= 1'b1;
         @(posedge clock);
         rd_strobe <= 1'b0;
         @(negedge clock);
         d = rd_data;
      end
   endtask : rd
endmodule : gdl_host

`default_nettype wire

/* tb/gdl_top_props.sv */
`timescale 1ns/1ns
`default_nettype none
`include "gdl_regs.svh"

module gdl_top_props
   import gdl_pkg::*;
(
   input wire logic                   clock,
   input wire logic                   rst,
   input wire logic [`GDL_ADDR_W-1:0] addr,
   input wire logic [`GDL_DATA_W-1:0] wr_data,
   input wire logic                   wr_strobe,
   input wire logic                   fault_clear_pulse,
   input wire gdl_hs_t                hs_cfg,
   input wire gdl_drv_t               drv_cfg,
   input wire logic                   locked,
   input wire logic [`GDL_MA_W-1:0]   source_ma,
   input wire logic [`GDL_MA_W-1:0]   sink_ma
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   wire logic wr_hs;
   assign wr_hs = wr_strobe && addr == `GDL_ADDR_HS_DRIVE;

   a_lock_enter: assert property (!locked && wr_hs && wr_data[10:8] == 3'h6 |=> locked)
      else $error("lock code did not lock");
   a_unlocked_stays: assert property (!locked && !(wr_hs && wr_data[10:8] == 3'h6) |=> !locked)
      else $error("lock set without lock code");
   a_unlock_code: assert property (locked && wr_hs && wr_data[10:8] == 3'h3 |=> !locked)
      else $error("unlock code did not unlock");
   a_locked_stays: assert property (locked && !(wr_hs && wr_data[10:8] == 3'h3) |=> locked)
      else $error("lock dropped without unlock code");
   a_codes_frozen: assert property (locked && wr_hs |=> $stable(hs_cfg[7:0]))
      else $error("drive codes changed while locked");
   a_drv_frozen: assert property (locked |=> drv_cfg[10:3] == $past(drv_cfg[10:3]))
      else $error("driver control upper bits changed while locked");
   a_codes_stored: assert property (!locked && wr_hs |=> hs_cfg[7:0] == $past(wr_data[7:0]))
      else $error("drive codes not stored");
   a_clear_pulse: assert property (wr_strobe && addr == `GDL_ADDR_DRV_CTRL && wr_data[0]
      |=> fault_clear_pulse ##1 !fault_clear_pulse)
      else $error("fault clear pulse wrong");
   a_src_decode: assert property (hs_cfg[7:4] == 4'h4 |=> source_ma == 12'h12c)
      else $error("source code 4 not 300 mA");
   a_sink_decode: assert property (hs_cfg[3:0] == 4'h2 |=> sink_ma == 12'h0c8)
      else $error("sink code 2 not 200 mA");
endmodule : gdl_top_props

bind gdl_top gdl_top_props u_props (.clock(clock), .rst(rst), .addr(addr), .wr_data(wr_data),
   .wr_strobe(wr_strobe), .fault_clear_pulse(fault_clear_pulse), .hs_cfg(hs_cfg),
   .drv_cfg(drv_cfg), .locked(locked), .source_ma(source_ma), .sink_ma(sink_ma));

`default_nettype wire

/* tb/gdl_top_test.sv */
`timescale 1ns/1ns
`default_nettype none

module gdl_top_test
   import gdl_pkg::*;
;
   logic        clock;
   logic        rst;
   logic [3:0]  addr;
   logic [15:0] wr_data, rd_data, d;
   logic        wr_strobe, rd_strobe, fault_clear_pulse, locked;
   logic [10:0] fault_event, latched_faults;
   gdl_hs_t     hs_cfg;
   gdl_drv_t    drv_cfg;
   logic [11:0] source_ma, sink_ma;
   int          failures, samples_checked, cycles;
   int src_tab[16] = '{50, 50, 100, 150, 300, 350, 400, 450, 550, 600, 650, 700, 850, 900, 950, 1000};
   int snk_tab[16] = '{100, 100, 200, 300, 600, 700, 800, 900, 1100, 1200, 1300, 1400, 1700, 1800,
                       1900, 2000};

   gdl_host host (.clock(clock), .addr(addr), .wr_data(wr_data), .wr_strobe(wr_strobe),
      .rd_strobe(rd_strobe), .rd_data(rd_data));
   gdl_top DUT (.clock(clock), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_strobe(wr_strobe),
      .rd_strobe(rd_strobe), .rd_data(rd_data), .fault_event(fault_event),
      .latched_faults(latched_faults), .fault_clear_pulse(fault_clear_pulse), .hs_cfg(hs_cfg),
      .drv_cfg(drv_cfg), .locked(locked), .source_ma(source_ma), .sink_ma(sink_ma));

   task chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      begin
         samples_checked++;
         if (seen !== exp)
         begin
            failures++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
         end
      end
   endtask : chk

   task t_reset;
      begin
         chk("hs_cfg", hs_cfg, 16'h03ff);
         chk("source_ma", source_ma, 16'h03e8);
         chk("sink_ma", sink_ma, 16'h07d0);
         chk("rst_state", {locked, drv_cfg}, 16'h0000);
         chk("rst_faults", latched_faults, 16'h0000);
         host.rd(4'h3, d);
         chk("rd_hs", d, 16'h03ff);
         host.rd(4'h9, d);
         chk("rd_unmapped", d, 16'h0000);
         $display("test reset done");
      end
   endtask : t_reset

   // Lock field cycles through every non-locking value while unlocked
   task t_decode;
      logic [2:0] lk;
      begin
         for (int i = 0; i < 16; i++)
         begin
            lk = (i[2:0] == 3'h6) ? 3'h7 : i[2:0];
            host.wr(4'h3, {5'h00, lk, i[3:0], 4'(15 - i)});
            repeat (2) @(negedge clock);
            chk("locked", locked, 16'h0000);
            chk("hs_cfg", hs_cfg, {5'h00, 3'h3, i[3:0], 4'(15 - i)});
            chk("source_ma", source_ma, 16'(src_tab[i]));
            chk("sink_ma", sink_ma, 16'(snk_tab[15 - i]));
         end
         $display("test decode done");
      end
   endtask : t_decode

   task t_lock;
      begin
         host.wr(4'h3, 16'h0652);
         @(negedge clock);
         chk("lock_on", {locked, hs_cfg}, 16'h0e52);
         host.wr(4'h3, 16'h0000);
         @(negedge clock);
         chk("lock_hold", {locked, hs_cfg}, 16'h0e52);
         host.wr(4'h2, 16'h07ff);
         @(negedge clock);
         chk("drv_locked", {fault_clear_pulse, drv_cfg}, 16'h0807);
         @(negedge clock);
         chk("drv_after", {fault_clear_pulse, drv_cfg}, 16'h0006);
         host.rd(4'h2, d);
         chk("rd_drv", d, 16'h0006);
         host.rd(4'h3, d);
         chk("rd_locked", d, 16'h0652);
         host.rd(4'h7, d);
         chk("rd_status", d, 16'h0003);
         @(negedge clock);
         chk("rd_idle", rd_data, 16'h0000);
         host.wr(4'h7, 16'h0002);
         host.rd(4'h7, d);
         chk("rd_cleared", d, 16'h0001);
         host.wr(4'h3, 16'h0300);
         @(negedge clock);
         chk("unlock", {locked, hs_cfg}, 16'h0352);
         host.wr(4'h2, 16'h07fe);
         @(negedge clock);
         chk("drv_open", drv_cfg, 16'h07fe);
         $display("test lock done");
      end
   endtask : t_lock

   task t_fault;
      begin
         @(posedge clock);
         fault_event <= 11'h008;
         repeat (3) @(posedge clock);
         host.rd(4'h0, d);
         chk("rd_fault", d, 16'h0008);
         host.wr(4'h2, 16'h0001);
         @(negedge clock);
         chk("relatched", latched_faults, 16'h0008);
         @(posedge clock);
         fault_event <= 11'h000;
         repeat (4) @(negedge clock);
         chk("latched", latched_faults, 16'h0008);
         host.wr(4'h2, 16'h0001);
         @(negedge clock);
         chk("cleared", latched_faults, 16'h0000);
         $display("test fault done");
      end
   endtask : t_fault

   // Reset in mid-run while locked must come back unlocked
   task t_midreset;
      begin
         host.wr(4'h3, 16'h0600);
         @(posedge clock);
         rst <= 1'b1;
         repeat (2) @(posedge clock);
         rst <= 1'b0;
         @(negedge clock);
         chk("rst_lock", {locked, hs_cfg}, 16'h03ff);
         chk("rst_source", source_ma, 16'h03e8);
         host.rd(4'h3, d);
         chk("rst_rd_hs", d, 16'h03ff);
         $display("test midreset done");
      end
   endtask : t_midreset

   task final_report;
      begin
         $display("checked %0d failures %0d", samples_checked, failures);
         if (failures == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
         else
            $display("MISMATCHES SEEN");
         $finish;
      end
   endtask : final_report

   initial
   begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end

   // Whole run needs well under 300 cycles
   always @(posedge clock)
   begin
      cycles <= cycles + 1;
      if (cycles == 2000)
      begin
         failures++;
         final_report;
      end
   end

   initial
   begin
      rst = 1'b1;
      fault_event = 11'h000;
      failures = 0;
      samples_checked = 0;
      cycles = 0;
      repeat (3) @(posedge clock);
      rst <= 1'b0;
      @(negedge clock);
      t_reset;
      t_decode;
      t_lock;
      t_fault;
      t_midreset;
      final_report;
   end
endmodule : gdl_top_test

`default_nettype wire
